/* hdl/rtu_pkg.sv */
// Constants for the clock update and tamper time-stamp block
package rtu_pkg;

    // ========================================
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int HUND_PERIOD_NS = 10_000_000;
    localparam int HUND_CYCLES = HUND_PERIOD_NS / CLK_PERIOD_NS;
    localparam int WIN_NS = 1_000_000;
    localparam int WIN_CYCLES = WIN_NS / CLK_PERIOD_NS;

    // ========================================
    // Register offsets
    localparam logic [7:0] ADDR_SUBSEC = 8'h00;
    localparam logic [7:0] ADDR_SECONDS = 8'h01;
    localparam logic [7:0] ADDR_CENT_HOURS = 8'h03;
    localparam logic [7:0] ADDR_WEEKDAY = 8'h04;
    localparam logic [7:0] ADDR_CLOCK_LAST = 8'h07;
    localparam logic [7:0] ADDR_CAL = 8'h08;
    localparam logic [7:0] ADDR_FREEZE = 8'h0c;
    localparam logic [7:0] ADDR_FLAGS = 8'h0f;
    localparam logic [7:0] ADDR_TAMPER1 = 8'h14;
    localparam logic [7:0] ADDR_TAMPER2 = 8'h15;

    // ========================================
    // Field positions
    localparam int BIT_OSC_HALT = 7;
    localparam int BIT_FREEZE = 6;
    localparam int BIT_CENT_LOW = 6;
    localparam int BIT_CENT_HIGH = 7;
    localparam int BIT_ARM = 7;
    localparam int BIT_IRQ_EN = 6;
    localparam int BIT_STYLE = 5;
    localparam int BIT_POLARITY = 4;
    localparam int BIT_SAMPLE = 3;
    localparam int BIT_PULL = 2;
    localparam int BIT_FLAG_CH1 = 1;
    localparam int BIT_FLAG_CH2 = 0;

    // ========================================
    // Time bits of each clock byte, and values after reset
    localparam logic [7:0] TIME_MASK [8] = '{8'hff, 8'h7f, 8'h7f, 8'hff,
        8'h07, 8'h3f, 8'h1f, 8'hff};
    localparam logic [7:0] CLOCK_RST [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
        8'h01, 8'h01, 8'h01, 8'h00};
    localparam logic [7:0] CAL_RST = 8'h00;
    localparam logic [7:0] TAMPER_RST = 8'h00;

endpackage : rtu_pkg

/* hdl/rtu_tick.sv */
// Divider chain giving the hundredth tick and the sampling window
`timescale 1ns/1ps
`default_nettype none

module rtu_tick #(
    parameter int HUND_CYCLES = rtu_pkg::HUND_CYCLES,
    parameter int WIN_CYCLES = rtu_pkg::WIN_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic run,
    input wire logic restart,
    output logic hund_tick,
    output logic ms_window
);

    localparam int W = $clog2(HUND_CYCLES);
    localparam logic [W-1:0] LAST = W'(HUND_CYCLES - 1);
    localparam logic [W-1:0] WIN = W'(WIN_CYCLES);

    logic [W-1:0] cnt_q;

    generate
        if (HUND_CYCLES < 2 || WIN_CYCLES < 1 || WIN_CYCLES >= HUND_CYCLES)
        begin : g_bad
            $error("rtu_tick: window must be shorter than the tick period");
        end
    endgenerate

    // ========================================
    // Counter
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (restart) begin
            cnt_q <= '0;
        end else if (run) begin
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end

    assign hund_tick = run && !restart && (cnt_q == LAST);
    assign ms_window = run && !restart && (cnt_q < WIN);

endmodule : rtu_tick

`default_nettype wire

/* hdl/rtu_update.sv */
// Clock register update control with tamper and power-down time-stamp
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: Sampling mode checks the tamper input for about 1 ms once a second.
// R2: A disarmed or already tripped channel does no sensing at all.
// R3: With the oscillator stopped, sampling mode falls back to continuous.
// R4: Pull strength bit one picks the strong pull, zero the weak one.
// R5: A tamper event stops copying time into clock bytes 00h to 07h.
// R6: Disarming a channel clears its flag; copying resumes once no tamper flag is set.
// R7: Software disarms both channels before reading the live time.
// R8: Later tamper events keep the time-stamp of the first one.
// R9: While any channel is armed, power-down does not set update freeze.
// R10: Any clock byte write zeroes the sub-second byte; data written to 00h is dropped.
// R11: Century bits sit in 03h D7..D6, weekday in 04h D2..D0.
// R12: Oscillator halt bit in 01h D7 stops the oscillator; zero restarts it.
// R13: Any write to 00h-07h loads the counters and restarts the divider.
// R14: Software writes control bits in clock bytes before setting time.
// R15: Copying pauses during clock byte access and during battery backup.
// R16: Time and date are kept and shown in BCD.
// R17: Power-down after a power failure sets the update freeze bit when no channel is armed.
// R18: A freeze zeroes byte 00h, holds 01h-07h; counters keep running.
// R19: Clearing the update freeze bit lets copying resume.
// R20: A tamper flag sets on an event only while its channel is armed.
// R21: Tamper flags are read only and clear only when disarmed.
// R22: Second period and sample window come from the divider chain.
module rtu_update #(
    parameter int HUND_CYCLES = rtu_pkg::HUND_CYCLES,
    parameter int WIN_CYCLES = rtu_pkg::WIN_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic clock_access,
    input wire logic battery_backup,
    input wire logic [1:0] tamper_input,
    output logic [1:0] tamper_sense_en,
    output logic [1:0] tamper_pull_en,
    output logic [1:0] tamper_pull_strong,
    output logic [1:0] tamper_pull_up,
    output logic [1:0] tamper_flag,
    output logic update_freeze,
    output logic osc_enable
);

    // ========================================
    // Declarations
    logic [7:0] user_q [8];
    logic [7:0] int_q [8];
    logic [7:0] int_d [8];
    logic [7:0] cal_q;
    logic [7:0] tamper_q [2];
    logic [1:0] flag_q;
    logic [1:0] tin_meta_q;
    logic [1:0] tin_q;
    logic bb_meta_q;
    logic bb_q;
    logic bb_last_q;
    logic freeze_q;
    logic tfreeze_q;
    logic load_q;
    logic [7:0] reg_rdata_q;
    logic hund_tick;
    logic ms_window;
    logic osc_halt;
    logic clock_wr;
    logic frozen;
    logic copy_en;
    logic any_arm;
    logic sample_window;
    logic [1:0] eval;
    logic [1:0] event_hit;
    logic [1:0] disarm_wr;

    // ========================================
    // Helpers
    function automatic logic [8:0] bcd_step(input logic [7:0] v,
        input logic [7:0] last, input logic [7:0] first, input logic en);
        logic [8:0] r;
        r = {1'b0, v};
        if (en) begin
            if (v == last) begin
                r = {1'b1, first};
            end else if (v[3:0] == 4'h9) begin
                r = {1'b0, v[7:4] + 4'h1, 4'h0};
            end else begin
                r = {1'b0, v + 8'h01};
            end
        end
        return r;
    endfunction : bcd_step

    function automatic logic [7:0] month_days(input logic [7:0] mon,
        input logic [7:0] yr);
        logic leap;
        logic [7:0] r;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4
                        || yr[3:0] == 4'h8);
        case (mon)
            8'h02: r = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
            default: r = 8'h31;
        endcase
        return r;
    endfunction : month_days

    function automatic logic is_tamper_addr(input logic [7:0] a);
        return a == rtu_pkg::ADDR_TAMPER1 || a == rtu_pkg::ADDR_TAMPER2;
    endfunction : is_tamper_addr

    // ========================================
    // Decodes
    assign clock_wr = reg_wr && (reg_addr <= rtu_pkg::ADDR_CLOCK_LAST);
    assign osc_halt = user_q[1][rtu_pkg::BIT_OSC_HALT]; // R12
    assign osc_enable = !osc_halt; // R12
    assign frozen = freeze_q || tfreeze_q; // R5 R18
    // No copy while counters reload, else stale time overwrites the write
    assign copy_en = !frozen && !clock_access && !bb_q
                     && !load_q; // R15 R19 R6
    assign any_arm = tamper_q[0][rtu_pkg::BIT_ARM]
                     || tamper_q[1][rtu_pkg::BIT_ARM];
    assign sample_window = ms_window && (int_q[0] == 8'h00); // R1 R22

    // ========================================
    // Divider chain
    rtu_tick #(
        .HUND_CYCLES(HUND_CYCLES),
        .WIN_CYCLES(WIN_CYCLES)
    ) u_tick (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(!osc_halt),
        .restart(load_q),
        .hund_tick(hund_tick),
        .ms_window(ms_window)
    );

    // ========================================
    // Pin synchronisers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tin_meta_q <= 2'b00;
            tin_q <= 2'b00;
            bb_meta_q <= 1'b0;
            bb_q <= 1'b0;
            bb_last_q <= 1'b0;
        end else begin
            tin_meta_q <= tamper_input;
            tin_q <= tin_meta_q;
            bb_meta_q <= battery_backup;
            bb_q <= bb_meta_q;
            bb_last_q <= bb_q;
        end
    end

    // ========================================
    // Internal time counters in BCD
    always_comb begin
        logic [8:0] s;
        logic c;
        logic [1:0] cent;
        s = '0;
        c = hund_tick;
        cent = int_q[3][7:6];
        for (int i = 0; i < 8; i++) begin
            int_d[i] = int_q[i];
        end
        s = bcd_step(int_q[0], 8'h99, 8'h00, c); // R16
        int_d[0] = s[7:0];
        c = s[8];
        s = bcd_step({1'b0, int_q[1][6:0]}, 8'h59, 8'h00, c);
        int_d[1] = s[7:0];
        c = s[8];
        s = bcd_step({1'b0, int_q[2][6:0]}, 8'h59, 8'h00, c);
        int_d[2] = s[7:0];
        c = s[8];
        s = bcd_step({2'b00, int_q[3][5:0]}, 8'h23, 8'h00, c);
        c = s[8];
        if (c) begin
            int_d[4] = (int_q[4][2:0] == 3'h7) ? 8'h01
                       : {5'h00, int_q[4][2:0] + 3'h1}; // R11
        end
        int_d[3][5:0] = s[5:0];
        s = bcd_step({2'b00, int_q[5][5:0]},
            month_days(int_q[6], int_q[7]), 8'h01, c);
        int_d[5] = s[7:0];
        c = s[8];
        s = bcd_step({3'b000, int_q[6][4:0]}, 8'h12, 8'h01, c);
        int_d[6] = s[7:0];
        c = s[8];
        s = bcd_step(int_q[7], 8'h99, 8'h00, c);
        int_d[7] = s[7:0];
        if (s[8]) begin
            cent = cent + 2'b01;
        end
        int_d[3][7:6] = cent; // R11
    end

    // Counters run on through any freeze; a clock write reloads them
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 8; i++) begin
                int_q[i] <= rtu_pkg::CLOCK_RST[i];
            end
        end else if (load_q) begin
            for (int i = 0; i < 8; i++) begin
                int_q[i] <= user_q[i] & rtu_pkg::TIME_MASK[i]; // R13
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                int_q[i] <= int_d[i]; // R18
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            load_q <= 1'b0;
        end else begin
            load_q <= clock_wr; // R13
        end
    end

    // ========================================
    // User clock bytes
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 8; i++) begin
                user_q[i] <= rtu_pkg::CLOCK_RST[i];
            end
        end else if (clock_wr) begin
            user_q[0] <= 8'h00; // R10
            if (reg_addr != rtu_pkg::ADDR_SUBSEC) begin
                user_q[reg_addr[2:0]] <= reg_wdata; // R11 R13
            end
        end else if (frozen) begin
            user_q[0] <= 8'h00; // R18
        end else if (copy_en) begin
            for (int i = 0; i < 8; i++) begin
                user_q[i] <= (user_q[i] & ~rtu_pkg::TIME_MASK[i])
                             | int_q[i]; // R15
            end
        end
    end

    // ========================================
    // Control bytes
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cal_q <= rtu_pkg::CAL_RST;
        end else if (reg_wr && reg_addr == rtu_pkg::ADDR_CAL) begin
            cal_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            freeze_q <= 1'b0;
        end else if (bb_q && !bb_last_q && !any_arm) begin
            freeze_q <= 1'b1; // R17 R9
        end else if (reg_wr && reg_addr == rtu_pkg::ADDR_FREEZE) begin
            freeze_q <= reg_wdata[rtu_pkg::BIT_FREEZE]; // R19
        end
    end

    // ========================================
    // Tamper channels
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_tamper
            logic [7:0] cfg;
            logic [7:0] ch_addr;
            assign cfg = tamper_q[ch];
            assign ch_addr = (ch == 0) ? rtu_pkg::ADDR_TAMPER1
                                       : rtu_pkg::ADDR_TAMPER2;

            // Sensing only while armed and not yet tripped
            assign eval[ch] = cfg[rtu_pkg::BIT_ARM] && !flag_q[ch] // R2
                && (!cfg[rtu_pkg::BIT_SAMPLE] || osc_halt // R3
                    || sample_window); // R1
            assign event_hit[ch] = eval[ch]
                && (tin_q[ch] == cfg[rtu_pkg::BIT_POLARITY]); // R20
            assign disarm_wr[ch] = reg_wr && reg_addr == ch_addr
                && !reg_wdata[rtu_pkg::BIT_ARM];

            assign tamper_sense_en[ch] = eval[ch]; // R2
            assign tamper_pull_en[ch] = eval[ch]
                && !cfg[rtu_pkg::BIT_STYLE];
            assign tamper_pull_strong[ch] = cfg[rtu_pkg::BIT_PULL]; // R4
            assign tamper_pull_up[ch] = cfg[rtu_pkg::BIT_POLARITY];

            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    tamper_q[ch] <= rtu_pkg::TAMPER_RST;
                end else if (reg_wr && reg_addr == ch_addr) begin
                    tamper_q[ch] <= reg_wdata;
                end
            end

            // Event wins over a disarm in the same cycle
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    flag_q[ch] <= 1'b0;
                end else if (event_hit[ch]) begin
                    flag_q[ch] <= 1'b1; // R20
                end else if (disarm_wr[ch]) begin
                    flag_q[ch] <= 1'b0; // R21 R6
                end
            end
        end
    endgenerate

    // ========================================
    // Tamper time-stamp freeze
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tfreeze_q <= 1'b0;
        end else if (|event_hit) begin
            tfreeze_q <= 1'b1; // R5 R8
        end else if (flag_q == 2'b00) begin
            tfreeze_q <= 1'b0; // R6
        end
    end

    // ========================================
    // Read port
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr <= rtu_pkg::ADDR_CLOCK_LAST) begin
                reg_rdata_q <= user_q[reg_addr[2:0]]; // R16
            end else if (reg_addr == rtu_pkg::ADDR_CAL) begin
                reg_rdata_q <= cal_q;
            end else if (reg_addr == rtu_pkg::ADDR_FREEZE) begin
                reg_rdata_q <= {1'b0, freeze_q, 6'h00};
            end else if (reg_addr == rtu_pkg::ADDR_FLAGS) begin
                reg_rdata_q <= {6'h00, flag_q[0], flag_q[1]}; // R21
            end else if (is_tamper_addr(reg_addr)) begin
                reg_rdata_q <= tamper_q[reg_addr[0]];
            end else begin
                reg_rdata_q <= 8'h00;
            end
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign tamper_flag = flag_q;
    assign update_freeze = freeze_q;

endmodule : rtu_update

`default_nettype wire

/* dv/rtu_update_monitor.sv */
// Checker for the clock update and tamper time-stamp block
`timescale 1ns/1ps
`default_nettype none

module rtu_update_monitor #(
    parameter int WIN_CYCLES = 4
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic battery_backup,
    input wire logic [1:0] tamper_sense_en,
    input wire logic [1:0] tamper_pull_strong,
    input wire logic [1:0] tamper_flag,
    input wire logic update_freeze,
    input wire logic osc_enable
);
    // ========================================
    // Helper state
    logic [1:0] arm_q;
    logic samp_q;
    int run_q;
    logic frozen;
    logic dis1;
    assign frozen = update_freeze || (tamper_flag != 2'b00);
    assign dis1 = reg_wr && reg_addr == 8'h14 && !reg_wdata[7];

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            arm_q <= 2'b00;
            samp_q <= 1'b0;
        end else if (reg_wr && reg_addr == 8'h14) begin
            arm_q[0] <= reg_wdata[7];
            samp_q <= reg_wdata[3];
        end else if (reg_wr && reg_addr == 8'h15) begin
            arm_q[1] <= reg_wdata[7];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            run_q <= 0;
        end else if (!osc_enable || (reg_wr && reg_addr == 8'h14)) begin
            run_q <= 0;
        end else if (tamper_sense_en[0]) begin
            run_q <= run_q + 1;
        end else begin
            run_q <= 0;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // ========================================
    // Sequences
    sequence s_trip1;
        $rose(tamper_flag[0]);
    endsequence
    sequence s_disarm1;
        dis1 && !tamper_sense_en[0] ##1 1'b1;
    endsequence
    sequence s_wr_then_sub;
        reg_wr && reg_addr <= 8'h07 ##2 reg_rd && reg_addr == 8'h00;
    endsequence

    // ========================================
    // Assertions
    a_osc_halt_bit: assert property (reg_wr && reg_addr == 8'h01
        |=> osc_enable == !$past(reg_wdata[7])) else $error("osc enable");
    a_pull_select: assert property (reg_wr && reg_addr == 8'h14
        |=> tamper_pull_strong[0] == $past(reg_wdata[2]))
        else $error("pull strength");
    a_flag_armed: assert property (s_trip1
        |-> $past(tamper_sense_en[0])) else $error("flag without sense");
    a_trip_stops_sense: assert property (tamper_flag[0]
        |-> !tamper_sense_en[0]) else $error("sensing after trip");
    a_flag_holds: assert property (tamper_flag[0] && !dis1
        |=> tamper_flag[0]) else $error("flag lost");
    a_disarm_clears: assert property (s_disarm1
        |-> !tamper_flag[0]) else $error("flag not cleared");
    a_subsec_zero: assert property (s_wr_then_sub
        |=> reg_rdata == 8'h00) else $error("subsecond not zero");
    a_freeze_zero: assert property (reg_rd && reg_addr == 8'h00
        && frozen && $past(frozen) |=> reg_rdata == 8'h00)
        else $error("frozen subsecond");
    a_pd_freeze: assert property ($rose(battery_backup)
        && arm_q == 2'b00 |-> ##[2:5] update_freeze)
        else $error("no power down freeze");
    a_armed_no_freeze: assert property (arm_q != 2'b00 && !reg_wr
        && !update_freeze |=> !update_freeze) else $error("freeze armed");
    a_fallback_cont: assert property (!osc_enable && arm_q[0]
        && !tamper_flag[0] |-> tamper_sense_en[0])
        else $error("no continuous sense");
    a_window_len: assert property (samp_q && arm_q[0]
        |-> run_q <= WIN_CYCLES) else $error("window too long");
endmodule : rtu_update_monitor

bind rtu_update rtu_update_monitor #(.WIN_CYCLES(WIN_CYCLES)) mon_inst (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .battery_backup(battery_backup),
    .tamper_sense_en(tamper_sense_en),
    .tamper_pull_strong(tamper_pull_strong), .tamper_flag(tamper_flag),
    .update_freeze(update_freeze), .osc_enable(osc_enable));

`default_nettype wire

/* dv/rtu_host.sv */
// Host side model driving the byte register port
`timescale 1ns/1ps
`default_nettype none

module rtu_host (
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    output logic clock_access
);
    initial begin
        reg_addr = 8'h10;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        clock_access = 1'b0;
    end

    // Pointer on a clock byte stays marked until the bus goes idle or an access moves off the clock bytes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        clock_access = (a <= 8'h07);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        @(negedge clk_sys);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        clock_access = (a <= 8'h07);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        d = reg_rdata;
        reg_rd = 1'b0;
        @(negedge clk_sys);
    endtask : rd

    // Bus released: pointer off the clock bytes, data line toggling
    task automatic idle(input int n);
        clock_access = 1'b0;
        reg_addr = 8'h10;
        repeat (n) begin
            reg_wdata = ~reg_wdata;
            @(negedge clk_sys);
        end
    endtask : idle
endmodule : rtu_host

`default_nettype wire

/* dv/test_rtu_update.sv */
// Testbench for the clock update and tamper time-stamp block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("ERROR %s expected %h seen %h", n, e, g); end end

module test_rtu_update;
    logic clk_sys, reset, battery_backup, reg_wr, reg_rd, clock_access;
    logic [1:0] tamper_input, tamper_sense_en, tamper_pull_en;
    logic [1:0] tamper_pull_strong, tamper_pull_up, tamper_flag;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, s0;
    logic update_freeze, osc_enable;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int cnt;
    logic [15:0] rst_tab [12] = '{16'h0100, 16'h0300, 16'h0401, 16'h0501,
        16'h0601, 16'h0700, 16'h0800, 16'h0c00, 16'h0f00, 16'h1000,
        16'h1400, 16'h1500};

    rtu_update #(.HUND_CYCLES(20), .WIN_CYCLES(4)) rtu_update_inst (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .clock_access(clock_access),
        .battery_backup(battery_backup), .tamper_input(tamper_input),
        .tamper_sense_en(tamper_sense_en),
        .tamper_pull_en(tamper_pull_en),
        .tamper_pull_strong(tamper_pull_strong),
        .tamper_pull_up(tamper_pull_up), .tamper_flag(tamper_flag),
        .update_freeze(update_freeze), .osc_enable(osc_enable));
    rtu_host host (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .clock_access(clock_access));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task automatic count(input int n);
        cnt = 0;
        repeat (n) begin
            @(negedge clk_sys);
            cnt += tamper_sense_en[0];
        end
    endtask : count

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        reset = 1'b1;
        battery_backup = 1'b0;
        tamper_input = 2'b00;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        foreach (rst_tab[i]) begin
            host.rd(rst_tab[i][15:8], d);
            `CHK("reset value", rst_tab[i][7:0], d)
        end
        $display("test reset done");
        host.wr(8'h03, 8'hd5);
        host.wr(8'h04, 8'h05);
        host.wr(8'h00, 8'h37);
        host.rd(8'h00, d);
        `CHK("subsecond", 8'h00, d)
        host.rd(8'h03, d);
        `CHK("century hours", 8'hd5, d)
        host.rd(8'h04, d);
        `CHK("weekday", 8'h05, d)
        host.wr(8'h01, 8'h80);
        `CHK("osc stop", 1'b0, osc_enable)
        host.wr(8'h01, 8'h19);
        `CHK("osc run", 1'b1, osc_enable)
        host.idle(2100);
        host.rd(8'h01, d);
        `CHK("seconds carry", 8'h20, d)
        $display("test clock bytes done");
        host.wr(8'h14, 8'h94);
        host.wr(8'h15, 8'h90);
        `CHK("pull strength", 2'b01, tamper_pull_strong)
        `CHK("pull on", 2'b11, tamper_pull_en)
        `CHK("pull up", 2'b11, tamper_pull_up)
        `CHK("sensing", 2'b11, tamper_sense_en)
        tamper_input = 2'b01;
        host.idle(4);
        `CHK("flag ch1", 2'b01, tamper_flag)
        `CHK("sense stop", 2'b10, tamper_sense_en)
        host.rd(8'h00, d);
        `CHK("frozen subsecond", 8'h00, d)
        host.rd(8'h01, s0);
        host.idle(2100);
        host.rd(8'h01, d);
        `CHK("time stamp", s0, d)
        tamper_input = 2'b11;
        host.idle(2100);
        `CHK("flag ch2", 2'b11, tamper_flag)
        host.rd(8'h01, d);
        `CHK("first stamp", s0, d)
        host.wr(8'h0f, 8'hff);
        host.rd(8'h0f, d);
        `CHK("flags read only", 2'b11, d[1:0])
        host.wr(8'h14, 8'h00);
        `CHK("flag clear", 2'b10, tamper_flag)
        host.rd(8'h01, d);
        `CHK("still frozen", s0, d)
        host.wr(8'h15, 8'h00);
        host.idle(3);
        host.rd(8'h01, d);
        `CHK("live time", 1'b1, d != s0)
        `CHK("unarmed", 2'b00, tamper_flag)
        tamper_input = 2'b00;
        $display("test tamper done");
        host.wr(8'h14, 8'h98);
        count(2000);
        `CHK("window cycles", 4, cnt)
        host.wr(8'h01, 8'h80);
        count(50);
        `CHK("continuous", 50, cnt)
        host.wr(8'h01, 8'h00);
        $display("test sampling done");
        battery_backup = 1'b1;
        host.idle(8);
        `CHK("armed no freeze", 1'b0, update_freeze)
        battery_backup = 1'b0;
        host.wr(8'h14, 8'h00);
        host.idle(4);
        battery_backup = 1'b1;
        host.idle(8);
        `CHK("power down freeze", 1'b1, update_freeze)
        host.rd(8'h0c, d);
        `CHK("freeze bit", 8'h40, d)
        host.rd(8'h00, d);
        `CHK("freeze subsecond", 8'h00, d)
        host.wr(8'h0c, 8'h00);
        `CHK("freeze cleared", 1'b0, update_freeze)
        battery_backup = 1'b0;
        $display("test power down done");
        results();
    end
endmodule : test_rtu_update

`default_nettype wire
